// >>> rtl/pbw_pkg.sv
/*
  Package for the power-button wake sequencer: state codes, press timing,
  and the carrier structs for wake inputs and indicator outputs.
  Assumes a 40 MHz always-on standby clock.
*/
package pbw_pkg;

  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned SHORT_PRESS_S = 4;
  localparam int unsigned LONG_PRESS_S  = 6;
  localparam longint unsigned SHORT_CYC = longint'(SHORT_PRESS_S) * CLK_HZ;
  localparam longint unsigned LONG_CYC  = longint'(LONG_PRESS_S) * CLK_HZ;
  localparam real    DEBOUNCE_MS        = 10.0;
  localparam int unsigned DEBOUNCE_CYC  =
    int'(DEBOUNCE_MS * real'(CLK_HZ) / 1000.0);
  localparam int unsigned USB_HOLDOFF_MS  = 100;
  localparam int unsigned USB_HOLDOFF_CYC = USB_HOLDOFF_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W         = 32;

  typedef enum logic [2:0] {
    PBW_G3 = 3'h0,
    PBW_S0 = 3'h1,
    PBW_S3 = 3'h2,
    PBW_S4 = 3'h3,
    PBW_S5 = 3'h4
  } pbw_state_t;

  // raw wake event levels from the outside world
  typedef struct packed {
    logic rtc_alarm;
    logic lan_wake;
    logic usb_activity;
    logic pcie_wake;
  } pbw_wake_t;

  typedef struct packed {
    logic led_amber;
    logic led_on;
    logic led_standby;
  } pbw_led_t;

endpackage : pbw_pkg

// >>> rtl/pbw_sync.sv
/*
  Three-stage synchroniser with agreement filter for asynchronous levels.
  Assumes the input comes from a pin or another clock domain.
*/
module pbw_sync
  import pbw_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  input  wire logic [WIDTH-1:0] rst_val_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // stage one feeds stage two only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          q_o[g] <= 1'b0;
        end else if (s2_q[g] == s3_q[g]) begin
          q_o[g] <= s3_q[g];
        end
      end
    end
  endgenerate

  // rst_val_i kept for a future preset; unused inputs reduce to zero risk
  logic unused_rst_val;
  assign unused_rst_val = ^rst_val_i;

endmodule : pbw_sync

// >>> rtl/pbw_top.sv
/*
  Power-button wake sequencer: tracks working, sleep, soft-off and
  mechanical-off states, times power-switch presses and accepts wake events.
  Assumes a free-running standby clock, power-on reset on RST_I, and
  asynchronous pins for the switch and wake sources.
*/
// Notes on behaviour
// - off, short press powers on
// - on, press over six seconds forces off
// - sleep, press over six seconds powers off
// - sleep, short press wakes to working
// - on, short press sleeps or soft-offs by setting
// - four wake sources accepted from S3/S4/S5
// - pcie wake returns system to working
// - usb activity wakes from S3/S4/S5
// - network wake frame request powers up
// - usb wake from S4/S5 needs deep sleep off
// - network wake after G3 needs deep sleep off
// - usb wake ignored right after AC return
// - rtc, network, pcie wakes keep display asleep
// - rtc alarm wakes system from S5
// - last-power setting picks on or off after AC
// - S3 main supply off, amber or dark LED
// - S4/S5 only wake logic stays powered
// - S5 keeps no context, needs cold boot
// - standby LED lit whenever standby supply present
module pbw_top
  import pbw_pkg::*;
#(
  parameter longint unsigned SHORT_CYCLES    = SHORT_CYC,
  parameter longint unsigned LONG_CYCLES     = LONG_CYC,
  parameter int unsigned     DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int unsigned     HOLDOFF_CYCLES  = USB_HOLDOFF_CYC
) (
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  input  wire logic       PWR_SW_N_I,
  input  wire logic       RTC_ALARM_I,
  input  wire logic       LAN_WAKE_I,
  input  wire logic       USB_ACT_I,
  input  wire logic       PCIE_WAKE_N_I,
  input  wire logic       AC_PRESENT_I,
  input  wire logic       STBY_PRESENT_I,
  input  wire logic       SLEEP_TO_S3_I,
  input  wire logic       SLEEP_REQ_I,
  input  wire logic       SLEEP_TO_S4_I,
  input  wire logic       OS_OFF_REQ_I,
  input  wire logic       DEEP_SLEEP_EN_I,
  input  wire logic       LAST_STATE_EN_I,
  input  wire logic       DUAL_LED_I,
  output logic            MAIN_PWR_EN_O,
  output logic            MEM_CTX_KEEP_O,
  output logic            WAKE_LOGIC_PWR_O,
  output logic            COLD_BOOT_O,
  output logic            DISPLAY_ON_O,
  output logic            LED_ON_O,
  output logic            LED_AMBER_O,
  output logic            LED_STBY_O,
  output logic            SLEEP_BTN_REQ_O,
  output logic      [2:0] STATE_O
);

  localparam int unsigned PRESS_W = 40;

  // counters are sized once; refuse timings they cannot reach
  if (SHORT_CYCLES == 0 || LONG_CYCLES <= SHORT_CYCLES) begin : g_bad_press
    $error("pbw_top: press thresholds out of order");
  end
  if (LONG_CYCLES >= (64'h1 << PRESS_W)) begin : g_bad_long
    $error("pbw_top: long press exceeds press counter");
  end
  if (DEBOUNCE_CYCLES == 0 || HOLDOFF_CYCLES == 0) begin : g_bad_count
    $error("pbw_top: debounce and hold-off need nonzero counts");
  end

  //////////////////////////////////////////////////////////////////////////
  // synchronisers

  logic [6:0] raw_in;
  logic [6:0] syn;
  assign raw_in = {~PWR_SW_N_I, RTC_ALARM_I, LAN_WAKE_I, USB_ACT_I,
                   ~PCIE_WAKE_N_I, AC_PRESENT_I, STBY_PRESENT_I};

  pbw_sync #(.WIDTH(7)) u_sync (
    .clk_i     (CLK_I),
    .rst_i     (RST_I),
    .d_i       (raw_in),
    .rst_val_i (7'h00),
    .q_o       (syn)
  );

  logic      sw_raw;
  pbw_wake_t wk;
  logic      ac_ok;
  logic      stby_ok;
  assign sw_raw  = syn[6];
  assign wk      = syn[5:2];
  assign ac_ok   = syn[1];
  assign stby_ok = syn[0];

  //////////////////////////////////////////////////////////////////////////
  // switch debounce and press timing

  logic [CNT_W-1:0]   deb_cnt_q;
  logic               sw_q;
  logic [PRESS_W-1:0] press_cnt_q;
  logic               long_done_q;
  logic               sw_fall;
  logic               short_rel;
  logic               long_hit;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      deb_cnt_q <= '0;
      sw_q      <= 1'b0;
    end else if (sw_raw == sw_q) begin
      deb_cnt_q <= '0;
    end else if (deb_cnt_q >= CNT_W'(DEBOUNCE_CYCLES - 1)) begin
      deb_cnt_q <= '0;
      sw_q      <= sw_raw;
    end else begin
      deb_cnt_q <= deb_cnt_q + 1'b1;
    end
  end

  assign sw_fall   = sw_q && (sw_raw == sw_q ? 1'b0 :
                     deb_cnt_q >= CNT_W'(DEBOUNCE_CYCLES - 1));
  // release under four seconds; between four and six does nothing
  assign short_rel = sw_fall && !long_done_q &&
                     (press_cnt_q < PRESS_W'(SHORT_CYCLES));
  assign long_hit  = sw_q && !long_done_q &&
                     (press_cnt_q >= PRESS_W'(LONG_CYCLES));

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      press_cnt_q <= '0;
      long_done_q <= 1'b0;
    end else if (!sw_q) begin
      press_cnt_q <= '0;
      long_done_q <= 1'b0;
    end else begin
      // saturates at the long threshold, so a stuck switch never wraps
      if (press_cnt_q < PRESS_W'(LONG_CYCLES)) begin
        press_cnt_q <= press_cnt_q + 1'b1;
      end
      // one forced action per hold; the release is then ignored
      if (long_hit) begin
        long_done_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // AC loss tracking

  logic              ac_q;
  logic              was_on_q;
  logic              after_g3_q;
  logic [CNT_W-1:0]  hold_cnt_q;
  logic              ac_rise;
  logic              usb_block;
  // every AC return restarts the usb hold-off
  assign ac_rise   = ac_ok && !ac_q;
  assign usb_block = (hold_cnt_q != '0);

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ac_q       <= 1'b0;
      hold_cnt_q <= '0;
    end else begin
      ac_q <= ac_ok;
      if (ac_rise) begin
        hold_cnt_q <= CNT_W'(HOLDOFF_CYCLES);
      end else if (hold_cnt_q != '0) begin
        hold_cnt_q <= hold_cnt_q - 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // wake qualification

  pbw_state_t state_q;
  pbw_state_t state_d;
  logic       in_sleep;
  logic       usb_ok;
  logic       lan_ok;
  logic       quiet_wake;
  logic       any_wake;

  assign in_sleep = (state_q == PBW_S3) || (state_q == PBW_S4) ||
                    (state_q == PBW_S5);
  // deep sleep cuts usb power in S4/S5
  assign usb_ok = wk.usb_activity && !usb_block &&
                  ((state_q == PBW_S3) || !DEEP_SLEEP_EN_I);
  assign lan_ok = wk.lan_wake &&
                  !(state_q == PBW_S5 && after_g3_q &&
                    DEEP_SLEEP_EN_I);
  // these sources bring the system up with the display left dark
  assign quiet_wake = wk.pcie_wake || lan_ok || wk.rtc_alarm;
  assign any_wake   = in_sleep && (quiet_wake || usb_ok);

  //////////////////////////////////////////////////////////////////////////
  // state machine

  always_comb begin
    state_d = state_q;
    case (state_q)
      PBW_G3: begin
        if (ac_ok) begin
          state_d = (LAST_STATE_EN_I && was_on_q) ? PBW_S0 :
                    PBW_S5;
        end
      end
      PBW_S0: begin
        if (long_hit) begin
          state_d = PBW_S5;
        end else if (short_rel && !SLEEP_REQ_I) begin
          state_d = PBW_S5;
        end else if (OS_OFF_REQ_I) begin
          state_d = PBW_S5;
        end else if (SLEEP_TO_S3_I) begin
          state_d = PBW_S3;
        end else if (SLEEP_TO_S4_I) begin
          state_d = PBW_S4;
        end
      end
      PBW_S3,
      PBW_S4: begin
        if (long_hit) begin
          state_d = PBW_S5;
        end else if (short_rel || any_wake) begin
          state_d = PBW_S0;
        end
      end
      PBW_S5: begin
        if (short_rel || any_wake) begin
          state_d = PBW_S0;
        end
      end
      default: begin
        state_d = PBW_G3;
      end
    endcase
    if (!ac_ok) begin
      state_d = PBW_G3;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_q <= PBW_G3;
    end else begin
      state_q <= state_d;
    end
  end

  // last power state and G3 history survive on standby battery
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      was_on_q   <= 1'b0;
      after_g3_q <= 1'b0;
    end else begin
      if (state_q != PBW_G3) begin
        was_on_q <= (state_q == PBW_S0);
      end
      if (state_q == PBW_G3) begin
        after_g3_q <= 1'b1;
      end else if (state_q == PBW_S0) begin
        after_g3_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // display handling

  logic disp_q;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      disp_q <= 1'b0;
    end else if (state_q != PBW_S0 && state_d == PBW_S0) begin
      // only a user press, usb, or a return from G3 brings the monitor back
      disp_q <= short_rel || (usb_ok && !quiet_wake) ||
                state_q == PBW_G3;
    end else if (state_d != PBW_S0) begin
      disp_q <= 1'b0;
    end else if (short_rel) begin
      disp_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registered outputs

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      MAIN_PWR_EN_O    <= 1'b0;
      MEM_CTX_KEEP_O   <= 1'b0;
      WAKE_LOGIC_PWR_O <= 1'b0;
      STATE_O          <= 3'h0;
    end else begin
      MAIN_PWR_EN_O    <= (state_d == PBW_S0);
      MEM_CTX_KEEP_O   <= (state_d == PBW_S0) ||
                          (state_d == PBW_S3);
      WAKE_LOGIC_PWR_O <= (state_d != PBW_G3);
      STATE_O          <= state_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // one-cycle pulses, then display and LED levels

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      COLD_BOOT_O     <= 1'b0;
      SLEEP_BTN_REQ_O <= 1'b0;
    end else begin
      // entering working from soft-off or mechanical-off always starts from scratch
      COLD_BOOT_O     <= (state_d == PBW_S0) && (state_q == PBW_S5 ||
                         state_q == PBW_G3);
      SLEEP_BTN_REQ_O <= (state_q == PBW_S0) && short_rel &&
                         SLEEP_REQ_I;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      DISPLAY_ON_O <= 1'b0;
      LED_ON_O     <= 1'b0;
      LED_AMBER_O  <= 1'b0;
    end else begin
      DISPLAY_ON_O <= disp_q;
      LED_ON_O     <= (state_q == PBW_S0);
      LED_AMBER_O  <= (state_q == PBW_S3) && DUAL_LED_I;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // standby indicator

  // follows the supply alone, so it stays lit while the board looks off
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      LED_STBY_O <= 1'b0;
    end else begin
      LED_STBY_O <= stby_ok;
    end
  end

endmodule : pbw_top

// >>> tb/pbw_properties.sv
/* Port-level assertions for pbw_top.
   Assumes a bind onto pbw_top and a single standby clock. */
module pbw_properties
  import pbw_pkg::*;
#(
  parameter longint unsigned LONG_CYCLES = LONG_CYC
) (
  input wire logic       CLK_I,
  input wire logic       RST_I,
  input wire logic       PWR_SW_N_I,
  input wire logic       STBY_PRESENT_I,
  input wire logic       MAIN_PWR_EN_O,
  input wire logic       MEM_CTX_KEEP_O,
  input wire logic       WAKE_LOGIC_PWR_O,
  input wire logic       COLD_BOOT_O,
  input wire logic       LED_AMBER_O,
  input wire logic       LED_STBY_O,
  input wire logic       SLEEP_BTN_REQ_O,
  input wire logic [2:0] STATE_O
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  //////////////////////////////////////////////////////////////////////////
  // raw hold length; 12 cycles of slack cover sync and debounce
  int unsigned hold_q;
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) hold_q <= 0;
    else if (PWR_SW_N_I) hold_q <= 0;
    else if (hold_q < 1000) hold_q <= hold_q + 1;
  end
  sequence off_to_on_s;
    (STATE_O == PBW_S5) ##1 (STATE_O == PBW_S0);
  endsequence
  //////////////////////////////////////////////////////////////////////////
  main_pwr_a: assert property (
    MAIN_PWR_EN_O == (STATE_O == PBW_S0))
    else $error("main supply does not follow working state");
  mem_ctx_a: assert property (
    MEM_CTX_KEEP_O == (STATE_O inside {PBW_S0, PBW_S3}))
    else $error("memory context flag wrong for state");
  wake_pwr_a: assert property (
    WAKE_LOGIC_PWR_O == (STATE_O != PBW_G3))
    else $error("wake logic power wrong for state");
  amber_a: assert property (
    LED_AMBER_O |-> $past(STATE_O) == PBW_S3)
    else $error("amber lit outside suspend to memory");
  cold_boot_a: assert property (off_to_on_s |-> COLD_BOOT_O)
    else $error("no cold boot leaving soft-off");
  boot_pulse_a: assert property (COLD_BOOT_O |=> !COLD_BOOT_O)
    else $error("cold boot longer than one cycle");
  sleep_btn_a: assert property (
    SLEEP_BTN_REQ_O |-> STATE_O == PBW_S0 ##1 !SLEEP_BTN_REQ_O)
    else $error("sleep request pulse wrong");
  stby_led_a: assert property (STBY_PRESENT_I [*8] |-> LED_STBY_O)
    else $error("standby led dark with standby present");
  long_off_a: assert property (
    hold_q == LONG_CYCLES + 12 |-> STATE_O inside {PBW_S5, PBW_G3})
    else $error("long press did not power off");
endmodule : pbw_properties

// >>> tb/pbw_far.sv
/* Model of the switch, wake sources and supplies around pbw_top.
   Assumes callers invoke its tasks just after a rising clock edge. */
module pbw_far
  import pbw_pkg::*;
(
  input  wire logic clk_i,
  output logic      sw_n_o,
  output pbw_wake_t wake_o,
  output logic      ac_o,
  output logic      stby_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // switch has a pull-up, so release reads high
  initial begin
    sw_n_o = 1'b1;
    wake_o = '0;
    ac_o   = 1'b1;
    stby_o = 1'b1;
  end
  task automatic press(int n);
    sw_n_o = 1'b0;
    repeat (n) @(posedge clk_i);
    #2;
    sw_n_o = 1'b1;
  endtask : press
  // k: 0 pcie, 1 usb, 2 network, 3 rtc
  task automatic wake(int k);
    wake_o[k] = 1'b1;
    repeat (10) @(posedge clk_i);
    #2;
    wake_o[k] = 1'b0;
  endtask : wake
  task automatic supply(logic a, logic s);
    ac_o   = a;
    stby_o = s;
  endtask : supply
endmodule : pbw_far

// >>> tb/pbw_top_bench.sv
/* Self-checking bench for pbw_top with shortened press counts.
   Assumes pbw_far drives switch, wake and supply pins. */
module pbw_top_bench
  import pbw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    bit         s3;
    bit         sq;
    int         h;
    pbw_state_t e;
  } pbw_row_t;
  logic       clk, rst, to_s3, to_s4, sreq, deep, last, off_req, dual;
  logic       sw_n, ac, stby, disp, led_stby, btn_req, led_on, amber;
  pbw_wake_t  wake;
  logic [2:0] state;
  int         num_errors = 0;
  int         num_checks = 0;
  int         pulses = 0;
  pbw_row_t   rows[12] = '{
    '{0, 0, 10, PBW_S0},
    '{0, 0, 50, PBW_S0},
    '{0, 1, 10, PBW_S0},
    '{1, 0, 10, PBW_S0},
    '{1, 0, 50, PBW_S3},
    '{0, 0, 10, PBW_S0},
    '{1, 0, 80, PBW_S5},
    '{0, 0, 10, PBW_S0},
    '{0, 0, 80, PBW_S5},
    '{0, 0, 10, PBW_S0},
    '{0, 0, 10, PBW_S5},
    '{0, 0, 10, PBW_S0}
  };
  //////////////////////////////////////////////////////////////////////////
  pbw_far u_far (.clk_i(clk), .sw_n_o(sw_n), .wake_o(wake), .ac_o(ac),
                 .stby_o(stby));
  pbw_top #(
    .SHORT_CYCLES   (40),
    .LONG_CYCLES    (60),
    .DEBOUNCE_CYCLES(2),
    .HOLDOFF_CYCLES (20)
  ) DUT (
    .CLK_I           (clk),
    .RST_I           (rst),
    .PWR_SW_N_I      (sw_n),
    .RTC_ALARM_I     (wake.rtc_alarm),
    .LAN_WAKE_I      (wake.lan_wake),
    .USB_ACT_I       (wake.usb_activity),
    .PCIE_WAKE_N_I   (~wake.pcie_wake),
    .AC_PRESENT_I    (ac),
    .STBY_PRESENT_I  (stby),
    .SLEEP_TO_S3_I   (to_s3),
    .SLEEP_REQ_I     (sreq),
    .SLEEP_TO_S4_I   (to_s4),
    .OS_OFF_REQ_I    (off_req),
    .DEEP_SLEEP_EN_I (deep),
    .LAST_STATE_EN_I (last),
    .DUAL_LED_I      (dual),
    .MAIN_PWR_EN_O   (),
    .MEM_CTX_KEEP_O  (),
    .WAKE_LOGIC_PWR_O(),
    .COLD_BOOT_O     (),
    .DISPLAY_ON_O    (disp),
    .LED_ON_O        (led_on),
    .LED_AMBER_O     (amber),
    .LED_STBY_O      (led_stby),
    .SLEEP_BTN_REQ_O (btn_req),
    .STATE_O         (state)
  );
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (btn_req === 1'b1) pulses++;
  //////////////////////////////////////////////////////////////////////////
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc
  task automatic chk(string n, logic [2:0] e, logic [2:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic os(bit s4);
    to_s3 = !s4;
    to_s4 = s4;
    cyc(3);
    to_s3 = 1'b0;
    to_s4 = 1'b0;
    cyc(5);
    chk("sleep", s4 ? PBW_S4 : PBW_S3, state);
    chk("led_on", 3'h0, {2'h0, led_on});
    chk("amber", {2'h0, !s4 && dual}, {2'h0, amber});
  endtask : os
  task automatic wake_chk(int k, pbw_state_t e);
    u_far.wake(k);
    cyc(10);
    chk("wake", e, state);
  endtask : wake_chk
  task automatic ac_cycle(pbw_state_t e);
    u_far.supply(1'b0, 1'b1);
    cyc(10);
    chk("acloss", PBW_G3, state);
    u_far.supply(1'b1, 1'b1);
    cyc(10);
    chk("acback", e, state);
  endtask : ac_cycle
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #200us;
    num_errors++;
    print_verdict();
  end
  initial begin
    {rst, to_s3, to_s4, sreq, deep, last, off_req, dual} = 8'h81;
    cyc(2);
    chk("reset", PBW_G3, state);
    cyc(1);
    rst = 1'b0;
    cyc(10);
    chk("boot", PBW_S5, state);
    foreach (rows[i]) begin
      sreq = rows[i].sq;
      if (rows[i].s3) os(1'b0);
      u_far.press(rows[i].h);
      cyc(20);
      chk("press", rows[i].e, state);
    end
    chk("pulses", 3'h1, pulses[2:0]);
    for (int k = 0; k < 4; k++) begin
      os(1'b0);
      wake_chk(k, PBW_S0);
      chk("display", {2'h0, k == 1}, {2'h0, disp});
      chk("led_on", 3'h1, {2'h0, led_on});
    end
    deep = 1'b1;
    dual = 1'b0;
    os(1'b0);
    wake_chk(1, PBW_S0);
    dual = 1'b1;
    os(1'b1);
    wake_chk(1, PBW_S4);
    deep = 1'b0;
    wake_chk(1, PBW_S0);
    ac_cycle(PBW_S5);
    wake_chk(1, PBW_S5);
    cyc(20);
    wake_chk(1, PBW_S0);
    deep = 1'b1;
    ac_cycle(PBW_S5);
    wake_chk(2, PBW_S5);
    wake_chk(3, PBW_S0);
    deep = 1'b0;
    last = 1'b1;
    ac_cycle(PBW_S0);
    off_req = 1'b1;
    cyc(2);
    off_req = 1'b0;
    cyc(5);
    chk("osoff", PBW_S5, state);
    ac_cycle(PBW_S5);
    u_far.supply(1'b1, 1'b0);
    cyc(10);
    chk("stby", 3'h0, {2'h0, led_stby});
    u_far.supply(1'b1, 1'b1);
    cyc(10);
    chk("stby", 3'h1, {2'h0, led_stby});
    print_verdict();
  end
endmodule : pbw_top_bench

bind pbw_top pbw_properties #(.LONG_CYCLES(LONG_CYCLES)) u_props (
  .CLK_I           (CLK_I),
  .RST_I           (RST_I),
  .PWR_SW_N_I      (PWR_SW_N_I),
  .STBY_PRESENT_I  (STBY_PRESENT_I),
  .MAIN_PWR_EN_O   (MAIN_PWR_EN_O),
  .MEM_CTX_KEEP_O  (MEM_CTX_KEEP_O),
  .WAKE_LOGIC_PWR_O(WAKE_LOGIC_PWR_O),
  .COLD_BOOT_O     (COLD_BOOT_O),
  .LED_AMBER_O     (LED_AMBER_O),
  .LED_STBY_O      (LED_STBY_O),
  .SLEEP_BTN_REQ_O (SLEEP_BTN_REQ_O),
  .STATE_O         (STATE_O)
);
